// File: tb/fhsr_host.sv
// host bus master model for the register port
`timescale 1ns/1ps
module fhsr_host (
  input wire logic clock,
  output logic [2:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd,
  input wire logic [7:0] host_rdata
);
  // bus idle at time zero
  initial begin
    host_addr = 3'h0;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  // one-cycle write; released data flips so stale bytes never look valid
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    host_addr <= a;
    host_wdata <= (a == 3'h4) ? (d & 8'hDF) : d;
    host_wr <= 1'b1;
    @(posedge clock);
    host_wr <= 1'b0;
    host_wdata <= ~host_wdata;
  endtask
  // one-cycle read, data taken in the cycle after the strobe
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clock);
    host_rd <= 1'b0;
    #1;
    d = host_rdata;
  endtask
endmodule // fhsr_host

// File: tb/fhsr_regs_bench.sv
// self-checking bench of the status and rate register block
`timescale 1ns/1ps
module fhsr_regs_bench;
  import fhsr_pkg::*;
  logic clock = 1'b0, arst_n = 1'b0, host_wr, host_rd, ctrl_reset_req = 1'b0;
  logic [2:0] host_addr;
  logic [7:0] host_wdata, host_rdata, drive_type_config = 8'h00;
  logic [7:0] boot_drive_config = 8'h00, precomp_start_track = 8'h00, current_track = 8'h00;
  fhsr_mode_t floppy_mode = FHSR_MODE_NORMAL;
  logic [1:0] last_drive_sel = 2'h0, drive_rate_setting = 2'h0, rate_code;
  logic [3:0] drive_seek_active = 4'h0;
  logic cmd_busy = 1'b0, non_dma_exec = 1'b0, transfer_direction = 1'b0;
  logic host_transfer_request = 1'b0, data_access = 1'b0, ident_pin = 1'b0;
  fhsr_rate_t rate_kind;
  logic [2:0] precomp_select, p;
  logic precomp_active, density_output, low_power, soft_reset;
  logic [31:0] seed = 32'h97B43760, v;
  logic [7:0] d, te, lastw, pe;
  int n_errors = 0, num_checks = 0, cyc = 0;
  int exp_q[$];
  fhsr_regs u_dut (.clock, .arst_n, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
    .floppy_mode, .last_drive_sel, .ctrl_reset_req, .drive_type_config, .boot_drive_config,
    .drive_rate_setting, .drive_seek_active, .cmd_busy, .non_dma_exec, .transfer_direction,
    .host_transfer_request, .data_access, .precomp_start_track, .current_track, .ident_pin,
    .rate_code, .rate_kind, .precomp_select, .precomp_active, .density_output, .low_power,
    .soft_reset);
  fhsr_host u_host (.clock, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata);
  // ==========================================
  // clock, timeout and helpers
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected decoded rate from drive rate setting and code
  function automatic logic [7:0] kind(input int r, input int c);
    if (c == 3) return 8'h01;
    if (c == 0) return 8'h02;
    if (c == 2) return 8'h04;
    return (r == 1) ? 8'h02 : (r == 2) ? 8'h00 : 8'h03;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk("rate_code", 8'h02, {6'h0, rate_code});
    chk("density", 8'h01, {7'h0, density_output});
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      @(posedge clock);
      {host_transfer_request, transfer_direction, non_dma_exec} <= v[7:5];
      {cmd_busy, drive_seek_active} <= v[4:0];
      exp_q.push_back(int'(v[7:0]));
      u_host.rreg(3'h4, d);
      chk("status", 8'(exp_q.pop_front()), d);
    end
    for (int m = 0; m < 8; m++) begin
      v = rnd();
      @(posedge clock);
      floppy_mode <= fhsr_mode_t'(m / 4);
      last_drive_sel <= 2'(m);
      drive_type_config <= v[7:0];
      boot_drive_config <= v[15:8];
      u_host.wreg(3'h3, v[23:16]);
      u_host.rreg(3'h3, d);
      te = (v[7:0] >> (2 * (m % 4)));
      te = (m < 4) ? {6'h0, v[17:16]} : {2'b00, te[1:0], v[9:8], v[17:16]};
      chk("tape", te, d);
    end
    for (int r = 0; r < 3; r++) begin
      @(posedge clock);
      drive_rate_setting <= 2'(r);
      ident_pin <= r[0];
      repeat (4) @(posedge clock);
      for (int c = 0; c < 4; c++) begin
        v = rnd();
        p = (c == 3 - r) ? 3'h0 : (c == r) ? 3'h7 : v[2:0];
        lastw = {3'b000, p, 2'(c)};
        @(posedge clock);
        current_track <= v[15:8];
        precomp_start_track <= v[23:16];
        u_host.wreg(3'h4, lastw);
        repeat (2) @(posedge clock);
        #1;
        chk("rate_code", 8'(c), {6'h0, rate_code});
        chk("rate_kind", kind(r, c), {5'h0, rate_kind});
        pe = (p == 0) ? ((c == 3) ? 8'h01 : 8'h03) : {5'h0, p};
        chk("precomp", pe, {5'h0, precomp_select});
        chk("precomp_on", {7'h0, p != 7 && v[15:8] >= v[23:16]}, {7'h0, precomp_active});
        chk("density", {7'h0, (c == 3 || c == 0) == r[0]}, {7'h0, density_output});
      end
      u_host.wreg(3'h7, 8'(3 - r));
      #1;
      chk("rate_code", 8'(3 - r), {6'h0, rate_code});
      u_host.wreg(3'h4, lastw);
    end
    for (int i = 0; i < 3; i++) begin
      u_host.wreg(3'h4, lastw | 8'h40);
      @(posedge clock);
      #1;
      chk("low_power", 8'h01, {7'h0, low_power});
      if (i == 0) u_host.rreg(3'h4, d);
      else begin
        @(posedge clock);
        host_transfer_request <= 1'b1;
        {ctrl_reset_req, data_access} <= 2'(i);
        @(posedge clock);
        {ctrl_reset_req, data_access} <= 2'b00;
      end
      repeat (2) @(posedge clock);
      #1;
      chk("low_power", 8'h00, {7'h0, low_power});
    end
    u_host.wreg(3'h4, lastw | 8'hC0);
    #1;
    chk("soft_reset", 8'h01, {7'h0, soft_reset});
    @(posedge clock);
    #1;
    chk("soft_reset", 8'h00, {7'h0, soft_reset});
    chk("low_power", 8'h00, {7'h0, low_power});
    chk("rate_code", {6'h0, lastw[1:0]}, {6'h0, rate_code});
    u_host.rreg(3'h3, d);
    chk("tape", te, d);
    results();
  end
endmodule // fhsr_regs_bench

// File: verilog/fhsr_map.svh
// offsets, field positions, reset values and figures of the status and rate registers
`ifndef FHSR_MAP_SVH
`define FHSR_MAP_SVH
// ==========================================
// register offsets
`define FHSR_OFF_TAPE 3'h3
`define FHSR_OFF_STATUS 3'h4
`define FHSR_OFF_RATE 3'h4
`define FHSR_OFF_CFGCTL 3'h7
// ==========================================
// rate select register fields
`define FHSR_RATE_RESET 8'h02
`define FHSR_BIT_SWRST 7
`define FHSR_BIT_LOWPWR 6
`define FHSR_PREC_HI 4
`define FHSR_PREC_LO 2
`define FHSR_PREC_DFLT 3'h0
`define FHSR_PREC_OFF 3'h7
`define FHSR_PREC_41NS 3'h1
`define FHSR_PREC_125NS 3'h3
// ==========================================
// rate codes and drive rate settings
`define FHSR_CODE_500 2'h0
`define FHSR_CODE_300 2'h1
`define FHSR_CODE_250 2'h2
`define FHSR_CODE_1M 2'h3
`define FHSR_DRT_3MODE 2'h1
`define FHSR_DRT_2MEG 2'h2
`define FHSR_DENSITY_RESET 1'b1
`endif

// File: verilog/fhsr_pkg.sv
// types shared by the status and rate register block
package fhsr_pkg;
  // decoded data rate
  typedef enum logic [2:0] {
    FHSR_RATE_2M,
    FHSR_RATE_1M,
    FHSR_RATE_500K,
    FHSR_RATE_300K,
    FHSR_RATE_250K
  } fhsr_rate_t;
  // tape register layout modes
  typedef enum logic {
    FHSR_MODE_NORMAL,
    FHSR_MODE_ENH2
  } fhsr_mode_t;
endpackage

// File: verilog/fhsr_regs.sv
// host status, rate select and tape register block of the floppy controller
`timescale 1ns/1ps
`include "fhsr_map.svh"

// Operation
// - enhanced mode: tape register bits 7:6 ignore writes, read zero
// - tape bits 5:4 give drive type pair of last selected drive
// - tape bits 3:2 give boot drive from boot config bits 1:0
// - tape bits 1:0 stay read/write tape select in both modes
// - status register read-only at offset 4, readable any time
// - status read shows current state, no wait after transfer
// - status bits 3:0 high while matching drive seeks
// - status bit 4 shows command in progress
// - status bit 5 high during polled execution phase
// - status bit 6 gives direction while request set
// - status bit 7 high means host may move a byte
// - rate select loads 0x02 on hardware reset, kept on soft reset
// - active rate is latest write of rate select or config control
// - rate select bits 4:2 pick precompensation, 000 per-rate default
// - precompensation applies from configurable start track, default 0
// - bit 6 enters low power; soft reset or data/status access exits
// - bit 7 issues self-clearing controller reset like output reg reset
// - rate codes map to 1M, 500, 300, 250 kbps; pins mirror code
// - drive rate 01 makes code 01 500k, drive rate 10 makes it 2M
// - density high for codes 1M and 500 when ident high, else inverted
// - soft reset leaves tape register unchanged
module fhsr_regs (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  input wire fhsr_pkg::fhsr_mode_t floppy_mode,
  input wire logic [1:0] last_drive_sel,
  input wire logic ctrl_reset_req,
  input wire logic [7:0] drive_type_config,
  input wire logic [7:0] boot_drive_config,
  input wire logic [1:0] drive_rate_setting,
  input wire logic [3:0] drive_seek_active,
  input wire logic cmd_busy,
  input wire logic non_dma_exec,
  input wire logic transfer_direction,
  input wire logic host_transfer_request,
  input wire logic data_access,
  input wire logic [7:0] precomp_start_track,
  input wire logic [7:0] current_track,
  input wire logic ident_pin,
  output logic [1:0] rate_code,
  output fhsr_pkg::fhsr_rate_t rate_kind,
  output logic [2:0] precomp_select,
  output logic precomp_active,
  output logic density_output,
  output logic low_power,
  output logic soft_reset
);
  import fhsr_pkg::*;

  // ==========================================
  // state
  logic [1:0] rate_reg;
  logic [1:0] rate_next;
  logic [2:0] prec_reg;
  logic [2:0] prec_next;
  logic [1:0] tape_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic lp_reg;
  logic lp_next;
  logic srst_reg;
  logic dens_reg;
  logic [2:0] psel_reg;
  logic pact_reg;
  fhsr_rate_t kind_reg;
  fhsr_rate_t kind_next;
  logic ident_meta;
  logic ident_sync;

  // ==========================================
  // address decode
  wire logic hit_tape = host_addr == `FHSR_OFF_TAPE;
  wire logic hit_stat = host_addr == `FHSR_OFF_STATUS;
  wire logic hit_cfg = host_addr == `FHSR_OFF_CFGCTL;
  wire logic wr_rate = host_wr && host_addr == `FHSR_OFF_RATE;
  wire logic wr_cfg = host_wr && hit_cfg;
  wire logic wr_tape = host_wr && hit_tape;
  wire logic rd_stat = host_rd && hit_stat;
  wire logic rd_tape = host_rd && hit_tape;
  wire logic is_enh = floppy_mode == FHSR_MODE_ENH2;

  // ==========================================
  // status and tape read values
  // live status, sampled on the read cycle itself
  wire logic [7:0] status_now = {host_transfer_request,
                                 transfer_direction,
                                 non_dma_exec,
                                 cmd_busy,
                                 drive_seek_active};

  // drive type pair picked by the last selected drive
  wire logic [1:0] type_pair = drive_type_config[{last_drive_sel, 1'b0} +: 2];
  wire logic [1:0] boot_pair = boot_drive_config[1:0];

  // upper bits read zero; normal mode leaves only the select bits
  wire logic [7:0] tape_now = is_enh ? {2'h0, type_pair, boot_pair, tape_reg}
                                     : {6'h00, tape_reg};

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    if (rd_stat) begin
      rdata_next = status_now;
    end else if (rd_tape) begin
      rdata_next = tape_now;
    end
  end

  // ==========================================
  // rate and precompensation selection
  // latest write of either register sets the rate
  always_comb begin
    rate_next = rate_reg;
    prec_next = prec_reg;
    if (wr_rate) begin
      rate_next = host_wdata[1:0];
      prec_next = host_wdata[`FHSR_PREC_HI:`FHSR_PREC_LO];
    end else if (wr_cfg) begin
      rate_next = host_wdata[1:0];
    end
  end

  // rate code to data rate, with drive rate remap of code 01
  always_comb begin
    case (rate_reg)
      `FHSR_CODE_1M: kind_next = FHSR_RATE_1M;
      `FHSR_CODE_500: kind_next = FHSR_RATE_500K;
      `FHSR_CODE_250: kind_next = FHSR_RATE_250K;
      default: begin
        if (drive_rate_setting == `FHSR_DRT_3MODE) begin
          kind_next = FHSR_RATE_500K;
        end else if (drive_rate_setting == `FHSR_DRT_2MEG) begin
          kind_next = FHSR_RATE_2M;
        end else begin
          kind_next = FHSR_RATE_300K;
        end
      end
    endcase
  end

  // default code stands for 41.67 ns at 1M and 125 ns elsewhere
  wire logic [2:0] psel_dflt = (kind_next == FHSR_RATE_1M) ? `FHSR_PREC_41NS
                                                            : `FHSR_PREC_125NS;
  wire logic [2:0] psel_next = (prec_reg == `FHSR_PREC_DFLT) ? psel_dflt : prec_reg;
  wire logic pact_next = (prec_reg != `FHSR_PREC_OFF) &&
                         (current_track >= precomp_start_track);
  // density follows code only; ident low inverts it
  wire logic dens_hi = (rate_reg == `FHSR_CODE_1M) || (rate_reg == `FHSR_CODE_500);
  wire logic dens_next = ident_sync ? dens_hi : !dens_hi;

  // ==========================================
  // low power and soft reset
  wire logic srst_req = wr_rate && host_wdata[`FHSR_BIT_SWRST];
  wire logic lp_exit = srst_req || ctrl_reset_req || data_access || rd_stat;
  // exit wins over entry so a reset write never parks the clock
  always_comb begin
    lp_next = lp_reg;
    if (lp_exit) begin
      lp_next = 1'b0;
    end else if (wr_rate && host_wdata[`FHSR_BIT_LOWPWR]) begin
      lp_next = 1'b1;
    end
  end

  // ==========================================
  // ident pin synchroniser
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ident_meta <= 1'b0;
      ident_sync <= 1'b0;
    end else begin
      ident_meta <= ident_pin;
      ident_sync <= ident_meta;
    end
  end

  // rate select fields, hardware reset only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rate_reg <= 2'(`FHSR_RATE_RESET);
      prec_reg <= `FHSR_PREC_DFLT;
    end else begin
      rate_reg <= rate_next;
      prec_reg <= prec_next;
    end
  end

  // tape select, untouched by soft reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tape_reg <= 2'h0;
    end else if (wr_tape) begin
      tape_reg <= host_wdata[1:0];
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // control flags
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lp_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      lp_reg <= lp_next;
      srst_reg <= srst_req;
    end
  end

  // registered decodes feeding the drive side
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dens_reg <= `FHSR_DENSITY_RESET;
      kind_reg <= FHSR_RATE_250K;
      psel_reg <= `FHSR_PREC_125NS;
      pact_reg <= 1'b0;
    end else begin
      dens_reg <= dens_next;
      kind_reg <= kind_next;
      psel_reg <= psel_next;
      pact_reg <= pact_next;
    end
  end

  // ==========================================
  // outputs
  assign host_rdata = rdata_reg;
  assign rate_code = rate_reg;
  assign rate_kind = kind_reg;
  assign precomp_select = psel_reg;
  assign precomp_active = pact_reg;
  assign density_output = dens_reg;
  assign low_power = lp_reg;
  assign soft_reset = srst_reg;

  // ==========================================
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_tape_top_zero: assert property (
    rd_tape |=> host_rdata[7:6] == 2'h0)
    else $error("tape top bits not zero");

  a_tape_type_pair: assert property (
    rd_tape && is_enh
    |=> host_rdata[5:4] == $past(2'(drive_type_config >> (2 * last_drive_sel))))
    else $error("drive type pair wrong");

  a_tape_boot_bits: assert property (
    rd_tape && is_enh |=> host_rdata[3:2] == $past(boot_drive_config[1:0]))
    else $error("boot drive bits wrong");

  a_tape_sel_back: assert property (
    wr_tape ##1 !host_wr ##1 rd_tape |=> host_rdata[1:0] == $past(host_wdata[1:0], 3))
    else $error("tape select not read back");

  a_status_live: assert property (
    rd_stat |=> host_rdata == $past(status_now))
    else $error("status read stale");

  a_seek_bits: assert property (
    rd_stat |=> host_rdata[3:0] == $past(drive_seek_active))
    else $error("seek bits wrong");

  a_request_bit: assert property (
    rd_stat |=> host_rdata[7] == $past(host_transfer_request))
    else $error("request bit wrong");

  a_rate_latest: assert property (
    (wr_rate || wr_cfg) |=> rate_code == $past(host_wdata[1:0]))
    else $error("rate not latest write");

  a_rate_hold: assert property (
    !wr_rate && !wr_cfg |=> $stable(rate_code))
    else $error("rate changed without write");

  a_prec_default: assert property (
    prec_reg == 3'h0 && rate_reg == 2'h3 && !wr_rate && !wr_cfg
    |=> ##1 precomp_select == 3'h1)
    else $error("1M default precomp wrong");

  a_lp_exit: assert property (
    low_power && (data_access || rd_stat) |=> !low_power)
    else $error("low power not left");

  a_srst_pulse: assert property (
    srst_req |=> soft_reset ##1 (!soft_reset || $past(srst_req)))
    else $error("soft reset not self clearing");

  a_rate_2m: assert property (
    rate_reg == 2'h1 && drive_rate_setting == 2'h2 |=> rate_kind == FHSR_RATE_2M)
    else $error("2M remap missing");

  a_density_map: assert property (
    ##1 density_output == ($past(ident_sync) ~^ $past(rate_code[1] ~^ rate_code[0])))
    else $error("density wrong");

  a_busy_bit: assert property (
    rd_stat |=> host_rdata[4] == $past(cmd_busy))
    else $error("command busy bit wrong");

  a_nondma_bit: assert property (
    rd_stat |=> host_rdata[5] == $past(non_dma_exec))
    else $error("non dma bit wrong");

  a_direction_bit: assert property (
    rd_stat |=> host_rdata[6] == $past(transfer_direction))
    else $error("direction bit wrong");

  a_write_no_data: assert property (
    wr_rate |=> host_rdata == 8'h00)
    else $error("rate write returned data");

  a_tape_normal: assert property (
    rd_tape && !is_enh |=> host_rdata[7:2] == 6'h00)
    else $error("normal tape upper bits set");

  a_tape_kept: assert property (
    !wr_tape |=> $stable(tape_reg))
    else $error("tape select changed without write");

  a_prec_code: assert property (
    wr_rate && host_wdata[`FHSR_PREC_HI:`FHSR_PREC_LO] != 3'h0
    |=> ##1 precomp_select == $past(host_wdata[`FHSR_PREC_HI:`FHSR_PREC_LO], 2))
    else $error("precomp code not applied");

  a_prec_off: assert property (
    prec_reg == 3'h7 |=> !precomp_active)
    else $error("precomp not disabled");

  a_prec_track: assert property (
    current_track < precomp_start_track |=> !precomp_active)
    else $error("precomp before start track");

  a_rate_1m: assert property (
    rate_reg == 2'h3 |=> rate_kind == FHSR_RATE_1M)
    else $error("1M rate decode wrong");

  a_rate_3mode: assert property (
    rate_reg == 2'h1 && drive_rate_setting == 2'h1 |=> rate_kind == FHSR_RATE_500K)
    else $error("code 01 remap to 500k missing");

  a_lp_enter: assert property (
    wr_rate && host_wdata[`FHSR_BIT_LOWPWR] && !host_wdata[`FHSR_BIT_SWRST] &&
    !data_access && !ctrl_reset_req
    |=> low_power)
    else $error("low power not entered");

  a_srst_wakes: assert property (
    srst_req |=> !low_power)
    else $error("soft reset kept low power");

  c_enh_tape_read: cover property (rd_tape && is_enh);
  c_low_power: cover property (low_power ##[1:20] !low_power);
  c_soft_reset: cover property (soft_reset);
  c_rate_2m: cover property (rate_kind == FHSR_RATE_2M);
  c_default_prec: cover property (prec_reg == 3'h0 && rate_reg == 2'h3);
endmodule // fhsr_regs
